/* File: src/servo_io_cfg.svh */
`ifndef SERVO_IO_CFG_SVH
`define SERVO_IO_CFG_SVH

// Control clock and servo-on delay.
`define CLK_HZ            64'd40000000
`define SERVO_ON_DELAY_MS 64'd100
`define SERVO_ON_CYCLES   (`SERVO_ON_DELAY_MS * `CLK_HZ / 64'd1000)

// Register byte offsets.
`define REG_IN_LOGIC      8'h00
`define REG_OUT_LOGIC     8'h04
`define REG_FUNC_ASSIGN   8'h08
`define REG_ZERO_CLAMP    8'h0c
`define REG_ATTAIN_SPEED  8'h10
`define REG_SPEED_LIMIT   8'h14
`define REG_STATUS        8'h18

// Reset values.
`define RST_IN_LOGIC      5'h00
`define RST_OUT_LOGIC     4'h0
`define RST_FUNC_ASSIGN   4'h0
`define RST_ZERO_CLAMP    1'b0
`define RST_ATTAIN_SPEED  16'h0064
`define RST_SPEED_LIMIT   16'h7fff

// Function assignment field positions.
`define FA_IN4_CLAMP      0
`define FA_IN5_TORQUE     1
`define FA_OUT3_CLAMP     2
`define FA_OUT4_TORQUE    3

// Largest speed magnitude that can be driven out.
`define SPEED_MAX         16'h7fff

`endif

/* File: src/servo_io_pkg.sv */
package servo_io_pkg;

  // Opto-isolated input pins, physical level.
  typedef struct packed {
    logic in5;
    logic in4;
    logic reverse_direction_enable;
    logic forward_direction_enable;
    logic servo_on;
  } in_pins_t;

  // Output transistors, high means transistor on.
  typedef struct packed {
    logic out4;
    logic out3;
    logic alarm;
    logic speed_reached_out;
  } out_pins_t;

  typedef enum logic [2:0] {
    PWR_OFF  = 3'b001,
    PWR_WAIT = 3'b010,
    PWR_ON   = 3'b100
  } power_state_t;

endpackage

/* File: src/servo_speed_io.sv */
// Our own choices: the register addresses and the Wishbone register port.
`include "servo_io_cfg.svh"

module servo_speed_io #(
  parameter int unsigned SERVO_ON_CYCLES = 32'(`SERVO_ON_CYCLES)
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Discrete pins
  input  wire servo_io_pkg::in_pins_t  pins_i,
  output servo_io_pkg::out_pins_t      pins_o,
  output logic                         marker_o,
  // Drive core
  input  wire logic                    init_done_i,
  input  wire logic                    fault_event_i,
  input  wire logic                    fault_fatal_i,
  input  wire logic                    encoder_index_i,
  input  wire logic signed [15:0]      velocity_command_in_i,
  input  wire logic signed [15:0]      measured_speed_i,
  output logic                         servo_power_o,
  output logic                         hold_position_o,
  output logic                         zero_speed_o,
  output logic                         torque_clamp_o,
  output logic signed [15:0]           speed_ref_o
);
  import servo_io_pkg::*;

  function automatic logic [15:0] magnitude(input logic signed [15:0] v);
    magnitude = v[15] ? 16'(16'h0000 - v) : 16'(v);
  endfunction

  // Input synchronisers and filters.
  logic [4:0] raw;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] filt;
  logic [4:0] next_filt;

  assign raw = pins_i;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end else begin
          sync1[g] <= raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
      // A level is taken only when two stages agree, which rejects single glitches.
      assign next_filt[g] = (sync2[g] == sync3[g]) ? sync3[g] : filt[g];
    end
  endgenerate

  // Registers.
  logic [4:0]   in_logic;
  logic [3:0]   out_logic;
  logic [3:0]   func_assign;
  logic         zero_clamp;
  logic [15:0]  attain_speed;
  logic [15:0]  speed_limit;
  logic [4:0]   next_in_logic;
  logic [3:0]   next_out_logic;
  logic [3:0]   next_func_assign;
  logic         next_zero_clamp;
  logic [15:0]  next_attain_speed;
  logic [15:0]  next_speed_limit;
  logic [31:0]  next_dat;
  logic         next_ack;
  logic [31:0]  status;
  logic         wb_req;
  logic         wb_wr;
  logic [31:0]  wmask;

  // Drive state.
  power_state_t       pwr;
  power_state_t       next_pwr;
  logic [31:0]        delay;
  logic [31:0]        next_delay;
  logic               alarm;
  logic               next_alarm;
  logic               ready;
  logic               clr_prev;
  out_pins_t          next_pins;
  logic               next_marker;
  logic               next_hold;
  logic               next_zero_speed;
  logic               next_torque;
  logic signed [15:0] next_speed;

  // Logical input levels after polarity.
  logic [4:0]  lin;
  logic        servo_on;
  logic        fwd;
  logic        rev;
  logic        fault_clear;
  logic        vclamp;
  logic        tclamp;
  logic        powered;
  logic        reverse_sense;
  logic [15:0] cmd_mag;

  assign lin      = filt ^ in_logic;
  assign servo_on = lin[0];
  assign fwd      = lin[1];
  assign rev      = lin[2];
  assign fault_clear = !func_assign[`FA_IN4_CLAMP] & lin[3];
  assign vclamp = (func_assign[`FA_IN4_CLAMP] & lin[3])
                | (!func_assign[`FA_IN5_TORQUE] & lin[4]);
  assign tclamp  = func_assign[`FA_IN5_TORQUE] & lin[4];
  assign powered = (pwr == PWR_ON);

  assign status = {23'h000000, tclamp, vclamp, zero_speed_o, hold_position_o,
                   rev, fwd, ready, alarm, powered};

  assign wb_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  // A write lands at the edge where the master samples ack, never before it.
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    next_in_logic     = in_logic;
    next_out_logic    = out_logic;
    next_func_assign  = func_assign;
    next_zero_clamp   = zero_clamp;
    next_attain_speed = attain_speed;
    next_speed_limit  = speed_limit;
    next_ack          = wb_req;
    next_dat          = wb_dat_o;
    if (wb_wr) begin
      case (wb_adr_i & 8'hfc)
        `REG_IN_LOGIC:
          next_in_logic = (in_logic & ~wmask[4:0]) | (wb_dat_i[4:0] & wmask[4:0]);
        `REG_OUT_LOGIC:
          next_out_logic = (out_logic & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
        `REG_FUNC_ASSIGN:
          next_func_assign = (func_assign & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
        `REG_ZERO_CLAMP:
          next_zero_clamp = wb_sel_i[0] ? wb_dat_i[0] : zero_clamp;
        `REG_ATTAIN_SPEED:
          next_attain_speed = (attain_speed & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `REG_SPEED_LIMIT:
          next_speed_limit = (speed_limit & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        default: ;
      endcase
    end
    if (wb_req) begin
      case (wb_adr_i & 8'hfc)
        `REG_IN_LOGIC:     next_dat = {27'h0000000, in_logic};
        `REG_OUT_LOGIC:    next_dat = {28'h0000000, out_logic};
        `REG_FUNC_ASSIGN:  next_dat = {28'h0000000, func_assign};
        `REG_ZERO_CLAMP:   next_dat = {31'h00000000, zero_clamp};
        `REG_ATTAIN_SPEED: next_dat = {16'h0000, attain_speed};
        `REG_SPEED_LIMIT:  next_dat = {16'h0000, speed_limit};
        `REG_STATUS:       next_dat = status;
        default:           next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_logic     <= `RST_IN_LOGIC;
      out_logic    <= `RST_OUT_LOGIC;
      func_assign  <= `RST_FUNC_ASSIGN;
      zero_clamp   <= `RST_ZERO_CLAMP;
      attain_speed <= `RST_ATTAIN_SPEED;
      speed_limit  <= `RST_SPEED_LIMIT;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h00000000;
    end else begin
      in_logic     <= next_in_logic;
      out_logic    <= next_out_logic;
      func_assign  <= next_func_assign;
      zero_clamp   <= next_zero_clamp;
      attain_speed <= next_attain_speed;
      speed_limit  <= next_speed_limit;
      wb_ack_o     <= next_ack;
      wb_dat_o     <= next_dat;
    end
  end

  // Servo power sequencing, alarm latch and output drive.
  always_comb begin
    next_pwr   = pwr;
    next_delay = 32'h00000000;
    // A new fault in the clearing cycle survives; a fatal fault blocks clearing only while fault_fatal_i is high.
    next_alarm = alarm;
    if (fault_clear && !clr_prev && !fault_fatal_i) begin
      next_alarm = 1'b0;
    end
    if (fault_event_i || fault_fatal_i) begin
      next_alarm = 1'b1;
    end
    case (pwr)
      PWR_OFF: begin
        if (servo_on && ready && !alarm) begin
          next_pwr = PWR_WAIT;
        end
      end
      PWR_WAIT: begin
        next_delay = 32'(delay + 32'h00000001);
        if (!servo_on || alarm) begin
          next_pwr = PWR_OFF;
        end else if (next_delay >= SERVO_ON_CYCLES) begin
          next_pwr = PWR_ON;
        end
      end
      PWR_ON: begin
        if (!servo_on || alarm) begin
          next_pwr = PWR_OFF;
        end
      end
      default: next_pwr = PWR_OFF;
    endcase

    // Direction decode: an odd one of the enables runs, equal enables stop.
    reverse_sense = velocity_command_in_i[15] ^ rev;
    cmd_mag = magnitude(velocity_command_in_i);
    if (vclamp && cmd_mag > speed_limit) begin
      cmd_mag = speed_limit;
    end
    if (cmd_mag > `SPEED_MAX) begin
      cmd_mag = `SPEED_MAX;
    end
    next_speed      = 16'sh0000;
    next_hold       = 1'b0;
    next_zero_speed = 1'b0;
    if (powered) begin
      if (fwd ^ rev) begin
        next_speed = reverse_sense ? 16'(16'h0000 - cmd_mag) : cmd_mag;
      end else if (zero_clamp) begin
        next_hold = 1'b1;
      end else begin
        next_zero_speed = 1'b1;
      end
    end
    next_torque = tclamp;

    next_pins.speed_reached_out =
      (magnitude(measured_speed_i) > attain_speed) ^ out_logic[0];
    next_pins.alarm = !alarm ^ out_logic[1];
    next_pins.out3  = (func_assign[`FA_OUT3_CLAMP] ? vclamp : ready) ^ out_logic[2];
    next_pins.out4  = (func_assign[`FA_OUT4_TORQUE] ? tclamp : vclamp) ^ out_logic[3];
    // Marker has no invert bit; it mirrors the index pulse directly.
    next_marker = encoder_index_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr             <= PWR_OFF;
      delay           <= 32'h00000000;
      alarm           <= 1'b0;
      ready           <= 1'b0;
      clr_prev        <= 1'b0;
      filt            <= 5'h00;
      pins_o          <= 4'h0;
      marker_o        <= 1'b0;
      servo_power_o   <= 1'b0;
      hold_position_o <= 1'b0;
      zero_speed_o    <= 1'b0;
      torque_clamp_o  <= 1'b0;
      speed_ref_o     <= 16'sh0000;
    end else begin
      pwr             <= next_pwr;
      delay           <= next_delay;
      alarm           <= next_alarm;
      ready           <= init_done_i;
      clr_prev        <= fault_clear;
      filt            <= next_filt;
      pins_o          <= next_pins;
      marker_o        <= next_marker;
      servo_power_o   <= (next_pwr == PWR_ON);
      hold_position_o <= next_hold;
      zero_speed_o    <= next_zero_speed;
      torque_clamp_o  <= next_torque;
      speed_ref_o     <= next_speed;
    end
  end

endmodule

/* File: test/servo_host_model.sv */
module servo_host_model (
  // Clock
  input  wire logic                   clk_i,
  // Requested levels and driven pins
  input  wire servo_io_pkg::in_pins_t want_i,
  output servo_io_pkg::in_pins_t      pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import servo_io_pkg::*;
  // Pins move only after an edge; the bench stops the motor before it moves the enables.
  always_ff @(posedge clk_i) begin
    pins_o <= want_i;
  end
endmodule

/* File: test/servo_speed_io_properties.sv */
module servo_speed_io_properties (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  // Bus
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [7:0]              wb_adr_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  // Pins and drive core
  input wire servo_io_pkg::out_pins_t pins_o,
  input wire logic                    marker_o,
  input wire logic                    fault_event_i,
  input wire logic                    fault_fatal_i,
  input wire logic                    encoder_index_i,
  input wire logic signed [15:0]      measured_speed_i,
  input wire logic                    servo_power_o,
  input wire logic                    hold_position_o,
  input wire logic                    zero_speed_o,
  input wire logic signed [15:0]      speed_ref_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_meas_steady;
    $stable(measured_speed_i) [*3];
  endsequence
  property p_ack_rise; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_unmapped;
    wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) >= 8'h1c) |-> wb_dat_o == 32'h0;
  endproperty
  property p_marker; marker_o == $past(encoder_index_i); endproperty
  property p_reached;
    s_meas_steady |-> pins_o.speed_reached_out ==
      (measured_speed_i > 16'sh0064 || measured_speed_i < -16'sh0064);
  endproperty
  property p_alarm; fault_fatal_i [*3] |-> !pins_o.alarm; endproperty
  property p_fault_power; fault_event_i |-> ##[1:3] !servo_power_o; endproperty
  property p_hold_power;
    hold_position_o || zero_speed_o |-> servo_power_o || $past(servo_power_o);
  endproperty
  property p_clamp_excl; !(hold_position_o && zero_speed_o); endproperty
  property p_ref_off;
    !servo_power_o && !$past(servo_power_o) |-> speed_ref_o == 16'sh0000;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("No ack after request.");
  a_ack_pulse: assert property (p_ack_pulse) else $error("Ack longer than a cycle.");
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");
  a_marker: assert property (p_marker) else $error("Marker off index.");
  a_reached: assert property (p_reached) else $error("Speed reached wrong.");
  a_alarm: assert property (p_alarm) else $error("Alarm output still on.");
  a_fault_power: assert property (p_fault_power) else $error("Power kept on fault.");
  a_hold_power: assert property (p_hold_power) else $error("Clamp while unpowered.");
  a_clamp_excl: assert property (p_clamp_excl) else $error("Hold and zero together.");
  a_ref_off: assert property (p_ref_off) else $error("Reference while unpowered.");
endmodule

bind servo_speed_io servo_speed_io_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o), .marker_o(marker_o),
  .fault_event_i(fault_event_i), .fault_fatal_i(fault_fatal_i),
  .encoder_index_i(encoder_index_i), .measured_speed_i(measured_speed_i),
  .servo_power_o(servo_power_o), .hold_position_o(hold_position_o),
  .zero_speed_o(zero_speed_o), .speed_ref_o(speed_ref_o));

/* File: test/servo_speed_io_bench.sv */
module servo_speed_io_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import servo_io_pkg::*;
  localparam int unsigned DELAY = 20;
  logic               clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, init_done = 1'b0;
  logic               f_evt = 1'b0, f_fatal = 1'b0, index = 1'b0, wb_ack_o, marker_o;
  logic               servo_power_o, hold_position_o, zero_speed_o, torque_clamp_o, f, r;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        wdat = 32'h0, rdat, wb_dat_o;
  logic signed [15:0] cmd = 16'sh0000, meas = 16'sh0000;
  // Kept unsigned so that compares against 16-bit expectations are not sign-extended.
  logic [15:0]        speed_ref_o;
  in_pins_t           want = '0, pins_i;
  out_pins_t          pins_o;
  int                 num_errors = 0, checks_done = 0, cycles = 0, n;

  servo_host_model u_host (.clk_i(clk_i), .want_i(want), .pins_o(pins_i));
  servo_speed_io #(.SERVO_ON_CYCLES(DELAY)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins_i),
    .pins_o(pins_o), .marker_o(marker_o), .init_done_i(init_done), .fault_event_i(f_evt),
    .fault_fatal_i(f_fatal), .encoder_index_i(index), .velocity_command_in_i(cmd),
    .measured_speed_i(meas), .servo_power_o(servo_power_o),
    .hold_position_o(hold_position_o), .zero_speed_o(zero_speed_o),
    .torque_clamp_o(torque_clamp_o), .speed_ref_o(speed_ref_o));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; the master waits for ack and then idles one cycle.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [15:0] exp_ref(logic fe, logic re, logic signed [15:0] c);
    if (fe == re) return 16'h0000;
    return fe ? c : -c;
  endfunction

  // Measured speed sits still for four cycles so the threshold compare can settle.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (!rst_i && cycles % 4 == 0) meas <= 16'($urandom % 401) - 16'sh00c8;
    index <= !rst_i && ($urandom % 8 == 0);
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h8de9));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h10, 32'h0); chk(rdat, 32'h64, "attain reset");
    bus(1'b0, 8'h14, 32'h0); chk(rdat, 32'h7fff, "limit reset");
    bus(1'b1, 8'h1c, 32'hffffffff);
    bus(1'b0, 8'h1c, 32'h0); chk(rdat, 32'h0, "unmapped");
    chk(pins_o.out3, 1'b0, "ready early");
    init_done <= 1'b1;
    repeat (4) @(posedge clk_i); chk(pins_o.out3, 1'b1, "ready");
    want.servo_on <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (servo_power_o !== 1'b1 && n < 200);
    chk(n >= DELAY && n <= DELAY + 8, 1'b1, "power delay");
    for (int zc = 0; zc < 2; zc++) begin
      bus(1'b1, 8'h0c, 32'(zc));
      for (int k = 0; k < 8; k++) begin
        f = k[0];
        r = k[1];
        cmd <= 16'sh0000;
        repeat (6) @(posedge clk_i);
        want.forward_direction_enable <= f;
        want.reverse_direction_enable <= r;
        repeat (6) @(posedge clk_i);
        cmd <= k[2] ? -16'($urandom % 32766 + 1) : 16'($urandom % 32766 + 1);
        repeat (8) @(posedge clk_i);
        chk(speed_ref_o, exp_ref(f, r, cmd), "reference");
        chk(hold_position_o, f == r && zc == 1, "hold");
        chk(zero_speed_o, f == r && zc == 0, "zero");
      end
    end
    want.reverse_direction_enable <= 1'b0;
    bus(1'b1, 8'h14, 32'h200);
    want.in5 <= 1'b1;
    cmd <= -16'sh1000;
    repeat (8) @(posedge clk_i); chk(speed_ref_o, 16'hfe00, "limited");
    chk(pins_o.out4, 1'b1, "limit indicator");
    bus(1'b1, 8'h08, 32'h2);
    repeat (6) @(posedge clk_i); chk(torque_clamp_o, 1'b1, "torque");
    chk(pins_o.out4, 1'b0, "limit gone");
    chk(speed_ref_o, 16'hf000, "unlimited");
    bus(1'b1, 8'h04, 32'h8);
    repeat (2) @(posedge clk_i); chk(pins_o.out4, 1'b1, "out invert");
    bus(1'b1, 8'h00, 32'h10);
    repeat (6) @(posedge clk_i); chk(torque_clamp_o, 1'b0, "in invert");
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h08, 32'h0);
    f_evt <= 1'b1;
    @(posedge clk_i);
    f_evt <= 1'b0;
    repeat (4) @(posedge clk_i); chk(pins_o.alarm, 1'b0, "alarm");
    chk(servo_power_o, 1'b0, "alarm power");
    chk(pins_o.out3, 1'b1, "ready in alarm");
    f_fatal <= 1'b1;
    want.in4 <= 1'b1;
    repeat (8) @(posedge clk_i); chk(pins_o.alarm, 1'b0, "fatal kept");
    want.in4 <= 1'b0;
    f_fatal <= 1'b0;
    repeat (6) @(posedge clk_i);
    want.in4 <= 1'b1;
    repeat (8) @(posedge clk_i); chk(pins_o.alarm, 1'b1, "cleared");
    repeat (DELAY + 10) @(posedge clk_i); chk(servo_power_o, 1'b1, "repower");
    want.servo_on <= 1'b0;
    repeat (8) @(posedge clk_i); chk(servo_power_o, 1'b0, "servo off");
    chk(speed_ref_o, 16'h0000, "free");
    finish_test();
  end
endmodule
